// File: hw/iosf_pkg.sv
package iosf_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 5;
  localparam int         DATA_W          = 16;
  localparam logic [4:0] REG_AO_FUNC     = 5'h00;
  localparam logic [4:0] REG_AO_GAIN     = 5'h01;
  localparam logic [4:0] REG_AO_SIGNAL   = 5'h02;
  localparam logic [4:0] REG_MAX_FREQ    = 5'h03;
  localparam logic [4:0] REG_RATED_CUR   = 5'h04;
  localparam logic [4:0] REG_PLC_VALUE   = 5'h05;
  localparam logic [4:0] REG_PI_ENABLE   = 5'h06;
  localparam logic [4:0] REG_PI_GAIN     = 5'h07;
  localparam logic [4:0] REG_PI_MIN      = 5'h08;
  localparam logic [4:0] REG_PI_OFFSET   = 5'h09;
  localparam logic [4:0] REG_PI_MAX      = 5'h0a;
  localparam logic [4:0] REG_PI_FILTER   = 5'h0b;
  localparam logic [4:0] REG_POLARITY    = 5'h0c;
  localparam logic [4:0] REG_DI_STATUS   = 5'h0d;
  localparam logic [4:0] REG_MEAS_FREQ   = 5'h0e;
  localparam logic [4:0] REG_PI_PERCENT  = 5'h0f;
  localparam logic [4:0] REG_AO_VALUE    = 5'h10;
  localparam logic [4:0] REG_PI_LEVEL    = 5'h11;

  // ----------------------------------------------------------------
  // Analog output
  // ----------------------------------------------------------------
  localparam logic [4:0]  FN_SPEED_REF   = 5'h00;
  localparam logic [4:0]  FN_SPEED_EFF   = 5'h02;
  localparam logic [4:0]  FN_CUR_RMS     = 5'h05;
  localparam logic [4:0]  FN_CUR_ACT     = 5'h07;
  localparam logic [4:0]  FN_TORQUE      = 5'h0b;
  localparam logic [4:0]  FN_PLC         = 5'h0c;
  localparam logic [4:0]  FN_OVERLOAD    = 5'h10;
  localparam logic [15:0] TORQUE_FS      = 16'h07d0;
  localparam logic [15:0] PLC_FS         = 16'h3fff;
  localparam logic [15:0] OVERLOAD_FS    = 16'h03e8;
  localparam logic [2:0]  SIG_V10        = 3'h0;
  localparam logic [2:0]  SIG_MA20       = 3'h1;
  localparam logic [2:0]  SIG_MA4_20     = 3'h2;
  localparam logic [2:0]  SIG_V10_INV    = 3'h3;
  localparam logic [2:0]  SIG_MA20_INV   = 3'h4;
  localparam logic [2:0]  SIG_MA4_20_INV = 3'h5;
  localparam logic [11:0] DAC_FS         = 12'hfff;
  localparam logic [11:0] DAC_LIVE_ZERO  = 12'h333;
  localparam logic [15:0] GAIN_ONE       = 16'h03e8;
  localparam logic [15:0] GAIN_MAX       = 16'h270f;

  // ----------------------------------------------------------------
  // Frequency input
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_LO        = 16'h0001;
  localparam logic [15:0] FREQ_HI        = 16'h0bb8;
  localparam logic [15:0] PI_MIN_RST     = 16'h0064;
  localparam logic [15:0] PI_MAX_RST     = 16'h03e8;
  localparam logic [15:0] PCT_FULL       = 16'h03e8;
  localparam logic [15:0] TC_MAX         = 16'h0640;
  localparam logic [15:0] TC_TICKS       = 16'h000a;
  localparam logic [9:0]  LEVEL_MAX      = 10'h3ff;
  localparam int          FILT_FRAC      = 8;
  localparam int          CLK_HZ         = 100000000;
  localparam int          GATE_TIME_MS   = 1000;
  localparam int          TICK_TIME_US   = 1000;
  localparam int          GATE_CYCLES    = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int          TICK_CYCLES    = CLK_HZ / 1000000 * TICK_TIME_US;

  // ----------------------------------------------------------------
  // Digital inputs
  // ----------------------------------------------------------------
  localparam logic [1:0]  POL_ALL_SINK   = 2'h0;
  localparam logic [1:0]  POL_LOW5_SRC   = 2'h2;
  localparam logic [7:0]  LOW5_MASK      = 8'h1f;
  localparam int          FI_BIT         = 2;

  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'b00,
    MEAS_GATE  = 2'b01,
    MEAS_LATCH = 2'b11
  } iosf_meas_t;

endpackage

// File: hw/iosf_top.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module iosf_top
  import iosf_pkg::*;
#(
  parameter int GATE_LEN = GATE_CYCLES,
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [15:0]       i_speed_ref,
  input  wire logic [15:0]       i_speed_eff,
  input  wire logic [15:0]       i_current_rms,
  input  wire logic [15:0]       i_current_active,
  input  wire logic [15:0]       i_torque_pct,
  input  wire logic [15:0]       i_overload_pct,
  input  wire logic [7:0]        i_di_pin,
  output logic      [DATA_W-1:0] o_rdata,
  output logic      [11:0]       o_ao_code,
  output logic      [7:0]        o_di_status,
  output logic      [9:0]        o_pi_level,
  output logic      [15:0]       o_pi_percent,
  output logic                   o_pi_reverse,
  output logic      [15:0]       o_pi_speed_ref
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  ao_func;
    logic [15:0] ao_gain;
    logic [2:0]  ao_sig;
    logic [15:0] max_freq;
    logic [15:0] rated_cur;
    logic [15:0] plc_val;
    logic        pi_en;
    logic [15:0] pi_gain;
    logic [15:0] pi_min;
    logic [15:0] pi_max;
    logic [15:0] pi_off;
    logic [15:0] pi_tc;
    logic [1:0]  pol;
    logic [7:0]  di_s1;
    logic [7:0]  di_s2;
    logic [7:0]  di_s3;
    logic [7:0]  di_stable;
    iosf_meas_t  meas;
    logic [31:0] gate_cnt;
    logic [15:0] pulse_cnt;
    logic [15:0] meas_hz;
    logic [31:0] tick_cnt;
    logic [31:0] filt;
    logic [15:0] rdata;
    logic [11:0] ao_code;
    logic [7:0]  di_stat;
    logic [9:0]  level;
    logic [15:0] pct;
    logic        rev;
    logic [15:0] spd;
  } iosf_state_t;

  iosf_state_t st;
  iosf_state_t next_st;

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) begin
      clamp_u = lo;
    end else if (v > hi) begin
      clamp_u = hi;
    end else begin
      clamp_u = v;
    end
  endfunction

  function automatic logic [11:0] ao_span(input logic [11:0] v, input logic [2:0] sig);
    logic [23:0] lz;
    lz = 24'(v) * 24'(DAC_FS - DAC_LIVE_ZERO) / 24'(DAC_FS);
    case (sig)
      SIG_V10, SIG_MA20:           ao_span = v;
      SIG_MA4_20:                  ao_span = DAC_LIVE_ZERO + lz[11:0];
      SIG_V10_INV, SIG_MA20_INV:   ao_span = DAC_FS - v;
      SIG_MA4_20_INV:              ao_span = DAC_FS - lz[11:0];
      default:                     ao_span = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Analog output scaling
  // ----------------------------------------------------------------
  logic [31:0] ao_val;
  logic [31:0] ao_fs;
  logic [31:0] ao_raw;
  logic [31:0] ao_gained;
  logic [11:0] ao_norm;

  always_comb begin
    case (st.ao_func)
      FN_SPEED_REF: ao_val = 32'(i_speed_ref);
      FN_SPEED_EFF: ao_val = 32'(i_speed_eff);
      FN_CUR_RMS:   ao_val = 32'(i_current_rms);
      FN_CUR_ACT:   ao_val = 32'(i_current_active);
      FN_TORQUE:    ao_val = 32'(i_torque_pct);
      FN_PLC:       ao_val = 32'(st.plc_val);
      FN_OVERLOAD:  ao_val = 32'(i_overload_pct);
      default:      ao_val = '0;
    endcase
    case (st.ao_func)
      FN_SPEED_REF, FN_SPEED_EFF: ao_fs = 32'(st.max_freq);
      FN_CUR_RMS, FN_CUR_ACT:     ao_fs = {15'h0000, st.rated_cur, 1'b0};
      FN_TORQUE:                  ao_fs = 32'(TORQUE_FS);
      FN_PLC:                     ao_fs = 32'(PLC_FS);
      FN_OVERLOAD:                ao_fs = 32'(OVERLOAD_FS);
      default:                    ao_fs = 32'(PLC_FS);
    endcase
    ao_fs = (ao_fs == '0) ? 32'h0000_0001 : ao_fs;
    // A value far above full scale is capped first so the gain product stays inside 32 bits.
    ao_raw = ao_val * 32'(DAC_FS) / ao_fs;
    ao_raw = (ao_raw > 32'h0000_ffff) ? 32'h0000_ffff : ao_raw;
    ao_gained = ao_raw * 32'(st.ao_gain) / 32'(GAIN_ONE);
    ao_norm   = (ao_gained > 32'(DAC_FS)) ? DAC_FS : ao_gained[11:0];
  end

  // ----------------------------------------------------------------
  // Frequency input arithmetic
  // ----------------------------------------------------------------
  logic [31:0] pi_den;
  logic [31:0] pi_rel;
  logic [31:0] pi_raw;
  logic [31:0] pi_diff;
  logic [31:0] pi_filt;
  logic [31:0] pi_lvl;
  logic [15:0] pi_mag;
  logic        fi_edge;

  always_comb begin
    pi_den  = (st.pi_max > st.pi_min) ? 32'(st.pi_max - st.pi_min) : 32'h0000_0001;
    pi_rel  = 32'(signed'({16'h0000, st.meas_hz}) - signed'({16'h0000, st.pi_min}));
    pi_raw  = 32'(signed'(pi_rel) * signed'(32'(PCT_FULL)) / signed'(pi_den));
    pi_raw  = 32'(signed'(pi_raw) + signed'(32'(signed'(st.pi_off))));
    pi_raw  = 32'(signed'(pi_raw) * signed'(32'(st.pi_gain)) / signed'(32'(GAIN_ONE)));
    pi_diff = 32'(signed'(pi_raw <<< FILT_FRAC) - signed'(st.filt));
    if (st.pi_tc == '0) begin
      pi_filt = pi_raw <<< FILT_FRAC;
    end else begin
      pi_filt = 32'(signed'(st.filt) + signed'(pi_diff) / signed'(32'(st.pi_tc) * 32'(TC_TICKS)));
    end
    pi_lvl  = (st.meas_hz <= st.pi_min) ? '0 : 32'(st.meas_hz - st.pi_min) * 32'(LEVEL_MAX) / pi_den;
    pi_mag  = st.pct[15] ? 16'(-st.pct) : st.pct;
    fi_edge = !st.di_stable[FI_BIT] && st.di_s2[FI_BIT] && st.di_s3[FI_BIT];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Pins cross into the clock domain through three stages; a level counts once two agree.
    next_st.di_s1 = i_di_pin;
    next_st.di_s2 = st.di_s1;
    next_st.di_s3 = st.di_s2;
    for (int k = 0; k < 8; k++) begin
      if (st.di_s2[k] == st.di_s3[k]) begin
        next_st.di_stable[k] = st.di_s3[k];
      end
      if (st.pol == POL_LOW5_SRC && LOW5_MASK[k]) begin
        next_st.di_stat[k] = st.di_stable[k];
      end else begin
        next_st.di_stat[k] = !st.di_stable[k];
      end
    end
    if (st.pi_en) begin
      next_st.di_stat[FI_BIT] = 1'b0;
    end

    case (st.meas)
      MEAS_IDLE: begin
        next_st.gate_cnt  = '0;
        next_st.pulse_cnt = '0;
        if (st.pi_en) begin
          next_st.meas = MEAS_GATE;
        end
      end
      MEAS_GATE: begin
        next_st.gate_cnt = st.gate_cnt + 32'h0000_0001;
        if (fi_edge && st.pulse_cnt < FREQ_HI) begin
          next_st.pulse_cnt = st.pulse_cnt + 16'h0001;
        end
        if (st.gate_cnt == 32'(GATE_LEN - 1)) begin
          next_st.meas = MEAS_LATCH;
        end
      end
      MEAS_LATCH: begin
        next_st.meas_hz   = st.pulse_cnt;
        next_st.gate_cnt  = '0;
        next_st.pulse_cnt = '0;
        next_st.meas      = MEAS_GATE;
      end
      default: begin
        next_st.meas = MEAS_IDLE;
      end
    endcase
    if (!st.pi_en) begin
      next_st.meas    = MEAS_IDLE;
      next_st.meas_hz = '0;
      next_st.filt    = '0;
    end

    if (st.tick_cnt == 32'(TICK_LEN - 1)) begin
      next_st.tick_cnt = '0;
      if (st.pi_en) begin
        next_st.filt = pi_filt;
      end
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
    end

    next_st.pct     = st.filt[FILT_FRAC+15:FILT_FRAC];
    next_st.rev     = st.pct[15];
    next_st.spd     = 16'(32'(pi_mag) * 32'(st.max_freq) / 32'(PCT_FULL));
    next_st.level   = (pi_lvl > 32'(LEVEL_MAX)) ? LEVEL_MAX : pi_lvl[9:0];
    next_st.ao_code = ao_span(ao_norm, st.ao_sig);

    if (i_wr) begin
      case (i_addr)
        REG_AO_FUNC:   next_st.ao_func   = i_wdata[4:0];
        REG_AO_GAIN:   next_st.ao_gain   = clamp_u(i_wdata, '0, GAIN_MAX);
        REG_AO_SIGNAL: next_st.ao_sig    = i_wdata[2:0];
        REG_MAX_FREQ:  next_st.max_freq  = i_wdata;
        REG_RATED_CUR: next_st.rated_cur = i_wdata;
        REG_PLC_VALUE: next_st.plc_val   = clamp_u(i_wdata, '0, PLC_FS);
        REG_PI_ENABLE: next_st.pi_en     = i_wdata[0];
        REG_PI_GAIN:   next_st.pi_gain   = clamp_u(i_wdata, '0, GAIN_MAX);
        REG_PI_MIN:    next_st.pi_min    = clamp_u(i_wdata, FREQ_LO, FREQ_HI);
        REG_PI_MAX:    next_st.pi_max    = clamp_u(i_wdata, FREQ_LO, FREQ_HI);
        REG_PI_OFFSET: begin
          if (signed'(i_wdata) > signed'(PCT_FULL)) begin
            next_st.pi_off = PCT_FULL;
          end else if (signed'(i_wdata) < -signed'(PCT_FULL)) begin
            next_st.pi_off = 16'(-PCT_FULL);
          end else begin
            next_st.pi_off = i_wdata;
          end
        end
        REG_PI_FILTER: next_st.pi_tc     = clamp_u(i_wdata, '0, TC_MAX);
        REG_POLARITY:  next_st.pol       = i_wdata[1:0];
        default:       next_st.pol       = st.pol;
      endcase
    end

    // Read data stands for the one cycle after the strobe and is zero otherwise.
    next_st.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_AO_FUNC:    next_st.rdata = 16'(st.ao_func);
        REG_AO_GAIN:    next_st.rdata = st.ao_gain;
        REG_AO_SIGNAL:  next_st.rdata = 16'(st.ao_sig);
        REG_MAX_FREQ:   next_st.rdata = st.max_freq;
        REG_RATED_CUR:  next_st.rdata = st.rated_cur;
        REG_PLC_VALUE:  next_st.rdata = st.plc_val;
        REG_PI_ENABLE:  next_st.rdata = 16'(st.pi_en);
        REG_PI_GAIN:    next_st.rdata = st.pi_gain;
        REG_PI_MIN:     next_st.rdata = st.pi_min;
        REG_PI_OFFSET:  next_st.rdata = st.pi_off;
        REG_PI_MAX:     next_st.rdata = st.pi_max;
        REG_PI_FILTER:  next_st.rdata = st.pi_tc;
        REG_POLARITY:   next_st.rdata = 16'(st.pol);
        REG_DI_STATUS:  next_st.rdata = 16'(st.di_stat);
        REG_MEAS_FREQ:  next_st.rdata = st.meas_hz;
        REG_PI_PERCENT: next_st.rdata = st.pct;
        REG_AO_VALUE:   next_st.rdata = 16'(st.ao_code);
        REG_PI_LEVEL:   next_st.rdata = 16'(st.level);
        default:        next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st          <= '0;
      st.ao_gain  <= GAIN_ONE;
      st.pi_gain  <= GAIN_ONE;
      st.pi_min   <= PI_MIN_RST;
      st.pi_max   <= PI_MAX_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata        = st.rdata;
  assign o_ao_code      = st.ao_code;
  assign o_di_status    = st.di_stat;
  assign o_pi_level     = st.level;
  assign o_pi_percent   = st.pct;
  assign o_pi_reverse   = st.rev;
  assign o_pi_speed_ref = st.spd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_gate_close;
    st.pi_en && st.meas == MEAS_LATCH;
  endsequence
  sequence s_gate_reopen;
    st.meas == MEAS_GATE && st.gate_cnt == '0 && st.meas_hz == $past(st.pulse_cnt);
  endsequence

  a_gate_latch_hz:    assert property (s_gate_close ##0 st.pi_en |=> s_gate_reopen)
    else $error("measured rate not latched at gate end");
  a_fi_off_zero:      assert property (!st.pi_en |=> st.meas_hz == '0 && st.meas == MEAS_IDLE)
    else $error("disabled pulse input shows a rate");
  a_di3_forced_low:   assert property (st.pi_en |=> !o_di_status[FI_BIT])
    else $error("input three status not held low");
  a_meas_in_band:     assert property (st.meas_hz <= FREQ_HI)
    else $error("measured rate above band");
  a_level_floor:      assert property (st.meas_hz <= st.pi_min |=> o_pi_level == '0)
    else $error("level not zero below band");
  a_reverse_sign:     assert property (##1 o_pi_reverse == $past(o_pi_percent[15]))
    else $error("reverse flag does not follow sign");
  a_sink_polarity:    assert property (st.pol == POL_ALL_SINK |=> o_di_status[0] == !$past(st.di_stable[0]))
    else $error("sinking input polarity wrong");
  a_span_inverted:    assert property (st.ao_sig == SIG_V10_INV && ao_norm == '0 |=> o_ao_code == DAC_FS)
    else $error("inverted span not at top");
  a_span_live_zero:   assert property (st.ao_sig == SIG_MA4_20 && ao_norm == '0 |=> o_ao_code == DAC_LIVE_ZERO)
    else $error("live zero span wrong");
  a_gain_clamped:     assert property (i_wr && i_addr == REG_AO_GAIN && i_wdata > GAIN_MAX |=> st.ao_gain == GAIN_MAX)
    else $error("gain not clamped");
  a_speed_full_scale: assert property (st.ao_func == FN_SPEED_REF && st.ao_gain == GAIN_ONE && st.ao_sig == SIG_V10
                                       && st.max_freq != '0 && i_speed_ref == st.max_freq |=> o_ao_code == DAC_FS)
    else $error("speed reference full scale wrong");

endmodule

// File: sim/iosf_field.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Field wiring and pulse source
// ----------------------------------------------------------------
// Static levels on all eight inputs, with a square pulse train on input three while a period is set.
module iosf_field (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_levels,
  input  wire logic [7:0] i_period,
  output logic      [7:0] o_pin
);
  logic [7:0] cnt;

  // The period stays at 8 cycles or more, inside the measurable band and slower than the sampler limit.
  always_ff @(posedge i_clk) begin
    if (i_period == 8'h00 || cnt >= i_period - 8'h01) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign o_pin = {i_levels[7:3], (i_period == 8'h00) ? i_levels[2] : (cnt < i_period / 2), i_levels[1:0]};
endmodule

// File: sim/iosf_top_tb.sv
`timescale 1ns/1ps

module iosf_top_tb
  import iosf_pkg::*;
;
  logic        i_clk;
  logic        i_rstn;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] spd;
  logic [15:0] cur;
  logic [15:0] trq;
  logic [15:0] ovl;
  logic [7:0]  lvl;
  logic [7:0]  per;
  logic [7:0]  pins;
  logic [15:0] o_rdata;
  logic [11:0] o_ao_code;
  logic [7:0]  o_di_status;
  logic [9:0]  o_pi_level;
  logic [15:0] o_pi_percent;
  logic        o_pi_reverse;
  logic [15:0] o_pi_speed_ref;
  logic [15:0] rdv;
  logic [7:0]  exp8;
  logic [31:0] seed = 32'ha11f50b7;
  int          failures = 0;
  int          total_checks = 0;
  logic [4:0]  fn_list [7] = '{FN_SPEED_REF, FN_SPEED_EFF, FN_CUR_RMS, FN_CUR_ACT, FN_TORQUE, FN_PLC, FN_OVERLOAD};
  logic [4:0]  rst_adr [6] = '{REG_AO_GAIN, REG_PI_GAIN, REG_PI_MIN, REG_PI_MAX, REG_PI_OFFSET, 5'h1f};
  logic [15:0] rst_val [6] = '{GAIN_ONE, GAIN_ONE, PI_MIN_RST, PI_MAX_RST, 16'h0000, 16'h0000};

  iosf_top #(.GATE_LEN(1000), .TICK_LEN(10)) u_dut (
    .i_addr(i_addr), .i_clk(i_clk), .i_rstn(i_rstn), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_speed_ref(spd), .i_speed_eff(spd), .i_current_rms(cur), .i_current_active(cur),
    .i_torque_pct(trq), .i_overload_pct(ovl), .i_di_pin(pins), .o_rdata(o_rdata), .o_ao_code(o_ao_code),
    .o_di_status(o_di_status), .o_pi_level(o_pi_level), .o_pi_percent(o_pi_percent), .o_pi_reverse(o_pi_reverse),
    .o_pi_speed_ref(o_pi_speed_ref));

  iosf_field u_field (.i_clk(i_clk), .i_levels(lvl), .i_period(per), .o_pin(pins));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Live-zero spans start at 0x333; inverted spans fall from the top.
  function automatic logic [15:0] ao_exp(input int s, input logic f);
    logic [11:0] lo;
    lo = (s == 2 || s == 5) ? DAC_LIVE_ZERO : 12'h000;
    return (s < 3) ? (f ? {4'h0, DAC_FS} : {4'h0, lo}) : (f ? {4'h0, lo} : {4'h0, DAC_FS});
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp, input int tol);
    int diff;
    total_checks++;
    diff = int'($signed(seen)) - int'($signed(exp));
    if ($isunknown(seen) || (tol == 0 && seen !== exp) || diff > tol || diff < -tol) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // The tests need about 4700 cycles; four times that means a hang.
  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata, lvl, per} = '0;
    {spd, cur, trq, ovl} = {16'd600, 16'd100, 16'd2000, 16'd1000};
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(rst_adr[k], rdv);
      chk("reset value", rdv, rst_val[k], 0);
    end
    $display("register default test done");
    wr(REG_MAX_FREQ, 16'd600);
    wr(REG_RATED_CUR, 16'd50);
    wr(REG_PLC_VALUE, 16'h3fff);
    for (int f = 0; f < 7; f++) begin
      wr(REG_AO_FUNC, {11'h000, fn_list[f]});
      for (int s = 0; s < 6; s++) begin
        wr(REG_AO_SIGNAL, 16'(s));
        repeat (3) @(posedge i_clk);
        chk("ao full", 16'(o_ao_code), ao_exp(s, 1'b1), 0);
      end
    end
    wr(REG_AO_FUNC, {11'h000, FN_PLC});
    for (int s = 0; s < 6; s++) begin
      wr(REG_AO_SIGNAL, 16'(s));
      wr(REG_AO_GAIN, GAIN_ONE);
      wr(REG_PLC_VALUE, 16'h0000);
      repeat (3) @(posedge i_clk);
      chk("ao zero", 16'(o_ao_code), ao_exp(s, 1'b0), 0);
      wr(REG_AO_GAIN, 16'hffff);
      rd(REG_AO_GAIN, rdv);
      chk("gain clamp", rdv, GAIN_MAX, 0);
      wr(REG_PLC_VALUE, 16'd1700 + 16'(xs() % 14684));
      repeat (3) @(posedge i_clk);
      chk("ao clamp", 16'(o_ao_code), ao_exp(s, 1'b1), 0);
    end
    $display("analog output test done");
    for (int k = 0; k < 8; k++) begin
      wr(REG_POLARITY, 16'(k % 4));
      lvl <= 8'(xs());
      repeat (8) @(posedge i_clk);
      exp8 = (2'(k) == POL_LOW5_SRC) ? ((lvl & LOW5_MASK) | (~lvl & ~LOW5_MASK)) : ~lvl;
      rd(REG_DI_STATUS, rdv);
      chk("di status", 16'(o_di_status), 16'(exp8), 0);
      chk("di status reg", rdv, 16'(exp8), 0);
    end
    $display("digital input test done");
    wr(REG_POLARITY, 16'h0000);
    wr(REG_PI_MIN, 16'd25);
    wr(REG_PI_MAX, 16'd225);
    per <= 8'd8;
    wr(REG_PI_ENABLE, 16'h0001);
    repeat (2600) @(posedge i_clk);
    rd(REG_MEAS_FREQ, rdv);
    chk("measured rate", rdv, 16'd125, 1);
    chk("level", 16'(o_pi_level), 16'd511, 6);
    chk("pulse bit", 16'(o_di_status & 8'h04), 16'h0000, 0);
    chk("percent", o_pi_percent, 16'd500, 6);
    chk("speed ref", o_pi_speed_ref, 16'd300, 4);
    chk("reverse", 16'(o_pi_reverse), 16'h0000, 0);
    wr(REG_PI_OFFSET, 16'hfc18);
    wr(REG_PI_GAIN, 16'd2000);
    repeat (50) @(posedge i_clk);
    chk("percent", o_pi_percent, 16'hfc18, 12);
    chk("reverse", 16'(o_pi_reverse), 16'h0001, 0);
    chk("speed ref", o_pi_speed_ref, 16'd600, 8);
    wr(REG_PI_FILTER, 16'd1);
    wr(REG_PI_OFFSET, 16'h0000);
    repeat (35) @(posedge i_clk);
    chk("filter step", o_pi_percent, 16'hfe36, 160);
    repeat (1500) @(posedge i_clk);
    chk("filter settle", o_pi_percent, 16'd1000, 12);
    wr(REG_PI_ENABLE, 16'h0000);
    repeat (4) @(posedge i_clk);
    rd(REG_MEAS_FREQ, rdv);
    chk("rate disabled", rdv, 16'h0000, 0);
    $display("frequency input test done");
    close_out();
  end
endmodule
